// >>> reference_clock_in_lock_and_rate_meter.sv
/*
 * Reference clock control for a clock recovery receiver: lock-to-reference
 * steering and data rate measurement against the reference clock, with
 * the control and result registers behind an 8-bit register port.
 * Assumes the serial interface front end drives the register port on clk,
 * and the recovery loop supplies dataTick and lockLostFlag on clk.
 */
`timescale 1ns/1ps
module reference_clock_in_lock_and_rate_meter #(
	parameter int MEAS_LIMIT = reference_clock_in_rate_pkg::MEAS_LIMIT_CYC
) (
	input  wire logic       clk,              // system clock, 125 MHz
	input  wire logic       rstn,             // synchronous reset
	input  wire logic       referenceClockIn, // reference clock
	input  wire logic [2:0] regAddr,          // register subaddress
	input  wire logic       regWrEn,          // register write strobe
	input  wire logic [7:0] regWrData,        // register write data
	input  wire logic       regRdEn,          // register read strobe
	output logic      [7:0] regRdData,        // read data, next cycle
	input  wire logic       dataTick,         // one recovered clock tick
	input  wire logic       lockLostFlag,     // loop has lost lock
	output logic            refLockMode,      // loop steered by reference
	output logic      [3:0] lockRatio,        // data divide exponent
	output logic            refDivTick,       // divided reference event
	output logic            relockReq,        // start reacquire pulse
	output logic            refInUse          // reference is in use
);
	import reference_clock_in_rate_pkg::*;

	// written on clk, read by the reference domain synchronisers
	logic [7:0]       rateCtrl_r;
	logic             startTgl_r;

	// ---------------- reference clock domain ----------------
	logic             refRst1_r, refRst2_r;
	logic [1:0]       rangeS1_r, rangeS2_r;
	logic             startS1_r, startS2_r, startS3_r;
	logic [2:0]       divCnt_r;
	logic             refDivTgl_r;
	logic [WIN_W-1:0] winCnt_r;
	logic             winOpen_r;
	logic             winDoneTgl_r;

	wire              refRstn   = refRst2_r;
	wire  [1:0]       rangeRef  = rangeS2_r;
	wire              startEdge = startS2_r ^ startS3_r;
	wire  [2:0]       divMask   = 3'((4'h1 << rangeRef) - 4'h1);
	wire              refDivEvt = (divCnt_r & divMask) == divMask;
	wire  [WIN_W-1:0] winLoad   = WIN_W'(18'h1 << (WIN_BASE_EXP +
		int'(rangeRef))) - 18'h1;
	wire              winLast   = winOpen_r && winCnt_r == '0;

	always_ff @(posedge referenceClockIn) begin
		refRst1_r <= rstn;
		refRst2_r <= refRst1_r;
		rangeS1_r <= rateCtrl_r[RANGE_MSB:RANGE_LSB];
		rangeS2_r <= rangeS1_r;
		startS1_r <= startTgl_r;
		startS2_r <= startS1_r;
		startS3_r <= startS2_r;
	end

	// divides the reference by 2^range for the recovery loop
	// reference divide
	always_ff @(posedge referenceClockIn) begin
		if (!refRstn) begin
			divCnt_r    <= 3'h0;
			refDivTgl_r <= 1'b0;
		end else begin
			divCnt_r <= divCnt_r + 3'h1;
			if (refDivEvt)
				refDivTgl_r <= ~refDivTgl_r;
		end
	end

	// gate time of 2^(14+range) reference cycles
	// window length
	always_ff @(posedge referenceClockIn) begin
		if (!refRstn) begin
			winCnt_r     <= '0;
			winOpen_r    <= 1'b0;
			winDoneTgl_r <= 1'b0;
		end else if (startEdge) begin
			winCnt_r  <= winLoad;
			winOpen_r <= 1'b1;
		end else if (winLast) begin
			winOpen_r    <= 1'b0;
			winDoneTgl_r <= ~winDoneTgl_r;
		end else if (winOpen_r) begin
			winCnt_r <= winCnt_r - 18'h1;
		end
	end

	a_div_spacing: assert property (@(posedge referenceClockIn)
		disable iff (!refRstn)
		(refDivEvt && rangeRef != 2'h0 && $stable(rangeRef)) |=>
		!refDivEvt) else $error("divided reference event too early");
	a_window_load: assert property (@(posedge referenceClockIn)
		disable iff (!refRstn)
		$rose(winOpen_r) |-> winCnt_r == $past(winLoad))
		else $error("window not loaded with 2^(14+range)-1");

	// ---------------- system clock domain ----------------
	logic [7:0]         actionCtrl_r;
	logic               winS1_r, winS2_r;
	logic               doneS1_r, doneS2_r, doneS3_r;
	logic               divS1_r, divS2_r, divS3_r;
	logic               lostPrev_r;
	logic               measDone_r;
	logic [COUNT_W-1:0] rateCount_r;
	logic [GUARD_W-1:0] guardCnt_r;
	meas_state_type     measState_r, measState_nxt;

	wire wrRate     = regWrEn && regAddr == ADDR_RATE_CTRL;
	wire wrAction   = regWrEn && regAddr == ADDR_ACTION;
	wire lockMode   = rateCtrl_r[LOCK_EN_BIT] && !rateCtrl_r[MEAS_EN_BIT];
	wire measMode   = rateCtrl_r[MEAS_EN_BIT] && !rateCtrl_r[LOCK_EN_BIT];
	wire lockEnRise = wrRate && regWrData[LOCK_EN_BIT] &&
		!regWrData[MEAS_EN_BIT] && !rateCtrl_r[LOCK_EN_BIT];
	wire restartFall = wrAction && !regWrData[RESTART_BIT] &&
		actionCtrl_r[RESTART_BIT];
	wire lostRise   = lockLostFlag && !lostPrev_r;
	wire winDoneEvt = doneS2_r ^ doneS3_r;
	wire divEvt     = divS2_r ^ divS3_r;
	wire guardOut   = guardCnt_r == GUARD_W'(MEAS_LIMIT - 1);
	wire running    = measState_r == MEAS_RUN;
	wire finishing  = (running && winDoneEvt) ||
		((running || measState_r == MEAS_ARM) && guardOut);
	wire countEn    = running && winS2_r && dataTick &&
		rateCount_r != '1;
	wire [7:0] statusByte = {5'h0, measDone_r, 1'b0, lockLostFlag};
	wire [7:0] rdMux =
		regAddr == ADDR_RATE_CTRL ? rateCtrl_r :
		regAddr == ADDR_ACTION    ? actionCtrl_r :
		regAddr == ADDR_STATUS    ? statusByte :
		regAddr == ADDR_CNT_HIGH  ? {1'b0, rateCount_r[22:16]} :
		regAddr == ADDR_CNT_MID   ? rateCount_r[15:8] :
		regAddr == ADDR_CNT_LOW   ? rateCount_r[7:0] : 8'h00;

	always_ff @(posedge clk) begin
		winS1_r  <= winOpen_r;
		winS2_r  <= winS1_r;
		doneS1_r <= winDoneTgl_r;
		doneS2_r <= doneS1_r;
		doneS3_r <= doneS2_r;
		divS1_r  <= refDivTgl_r;
		divS2_r  <= divS1_r;
		divS3_r  <= divS2_r;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rateCtrl_r   <= RATE_CTRL_RESET;
			actionCtrl_r <= ACTION_RESET;
		end else begin
			if (wrRate)
				rateCtrl_r <= regWrData;
			if (wrAction)
				actionCtrl_r <= regWrData;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			regRdData <= 8'h00;
		else if (regRdEn)
			regRdData <= rdMux;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			lostPrev_r  <= 1'b0;
			refLockMode <= 1'b0;
			lockRatio   <= 4'h0;
			refDivTick  <= 1'b0;
			relockReq   <= 1'b0;
			refInUse    <= 1'b0;
		end else begin
			lostPrev_r  <= lockLostFlag;
			refLockMode <= lockMode;
			lockRatio   <= rateCtrl_r[RATIO_MSB:RATIO_LSB];
			refDivTick  <= lockMode && divEvt;
			relockReq   <= lockEnRise || (lockMode && lostRise);
			refInUse    <= lockMode || measMode;
		end
	end

	a_relock_loss: assert property (@(posedge clk) disable iff (!rstn)
		(lockMode && lostRise) |=> relockReq)
		else $error("no reacquire after lock loss");
	a_lock_cmd: assert property (@(posedge clk) disable iff (!rstn)
		lockEnRise |=> relockReq ##1 refLockMode)
		else $error("lock command not issued");
	a_meas_hands_off: assert property (@(posedge clk) disable iff (!rstn)
		measMode |=> !refLockMode && !refDivTick && !relockReq)
		else $error("measurement disturbed lock acquisition");
	a_ref_ignored: assert property (@(posedge clk) disable iff (!rstn)
		(!lockMode && !measMode) |=> !refInUse && !refDivTick)
		else $error("reference used with no mode enabled");

	// measurement sequencing
	always_comb begin
		measState_nxt = measState_r;
		unique case (measState_r)
			MEAS_IDLE: measState_nxt = MEAS_IDLE;
			MEAS_ARM:  if (guardOut)
					measState_nxt = MEAS_DONE;
				else if (winS2_r)
					measState_nxt = MEAS_RUN;
			MEAS_RUN:  if (finishing)
					measState_nxt = MEAS_DONE;
			MEAS_DONE: measState_nxt = MEAS_DONE;
		endcase
		if (!measMode)
			measState_nxt = MEAS_IDLE;
		else if (restartFall)
			measState_nxt = MEAS_ARM;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			measState_r <= MEAS_IDLE;
			startTgl_r  <= 1'b0;
			guardCnt_r  <= '0;
		end else begin
			measState_r <= measState_nxt;
			if (measMode && restartFall)
				startTgl_r <= ~startTgl_r;
			if (measState_nxt == MEAS_ARM || measState_nxt == MEAS_RUN)
				guardCnt_r <= restartFall ? '0 : guardCnt_r + 25'h1;
			else
				guardCnt_r <= '0;
		end
	end

	// done flag, a completing measurement beats a clear
	always_ff @(posedge clk) begin
		if (!rstn)
			measDone_r <= 1'b0;
		else if (finishing)
			measDone_r <= 1'b1;
		else if (restartFall)
			measDone_r <= 1'b0;
	end

	// count recovered ticks within the window
	always_ff @(posedge clk) begin
		if (!rstn)
			rateCount_r <= '0;
		else if (measMode && restartFall)
			rateCount_r <= '0;
		else if (countEn)
			rateCount_r <= rateCount_r + 23'h1;
	end

	a_done_clear: assert property (@(posedge clk) disable iff (!rstn)
		(restartFall && !finishing) |=> !measDone_r)
		else $error("restart did not clear done");
	a_done_set: assert property (@(posedge clk) disable iff (!rstn)
		(finishing && !restartFall) |=>
		measDone_r && measState_r == MEAS_DONE)
		else $error("done not set at end of window");
	a_rerun_level: assert property (@(posedge clk) disable iff (!rstn)
		(measMode && measDone_r && restartFall && !wrRate) |=>
		measState_r == MEAS_ARM && !measDone_r)
		else $error("held enable did not allow a rerun");
	a_count_step: assert property (@(posedge clk) disable iff (!rstn)
		(running && !restartFall) |=>
		(rateCount_r == $past(rateCount_r) ||
		rateCount_r == $past(rateCount_r) + 23'h1))
		else $error("count moved by more than one tick");
	a_high_byte: assert property (@(posedge clk) disable iff (!rstn)
		(regRdEn && regAddr == ADDR_CNT_HIGH) |=>
		regRdData == {1'b0, $past(rateCount_r[22:16])})
		else $error("high count byte misplaced");
	a_busy_flag: assert property (@(posedge clk) disable iff (!rstn)
		(measState_r == MEAS_RUN) |-> !measDone_r || $past(finishing) ||
		$past(measDone_r))
		else $error("done raised while measuring");

endmodule

// >>> reference_clock_in_rate_pkg.sv
/*
 * Shared constants for the reference clock lock and data rate meter:
 * register offsets, field positions, reset values, timing counts and
 * the measurement state type.
 * Assumes an 8-bit register port addressed by a 3-bit subaddress.
 */
package reference_clock_in_rate_pkg;

	// register subaddresses
	localparam logic [2:0] ADDR_RATE_CTRL  = 3'h0;
	localparam logic [2:0] ADDR_ACTION     = 3'h1;
	localparam logic [2:0] ADDR_STATUS     = 3'h2;
	localparam logic [2:0] ADDR_CNT_HIGH   = 3'h3;
	localparam logic [2:0] ADDR_CNT_MID    = 3'h4;
	localparam logic [2:0] ADDR_CNT_LOW    = 3'h5;

	// rate_control fields
	localparam int LOCK_EN_BIT = 0;
	localparam int MEAS_EN_BIT = 1;
	localparam int RATIO_LSB   = 2;
	localparam int RATIO_MSB   = 5;
	localparam int RANGE_LSB   = 6;
	localparam int RANGE_MSB   = 7;

	// action_control and status fields
	localparam int RESTART_BIT     = 3;
	localparam int STAT_LOST_BIT   = 0;
	localparam int STAT_DONE_BIT   = 2;

	// divide exponent the host programs for locking (divide by 32)
	localparam logic [3:0] RATIO_LOCK = 4'h5;
	localparam logic [1:0] RANGE_DEFAULT = 2'h0;
	localparam logic [7:0] RATE_CTRL_RESET = {RANGE_DEFAULT, RATIO_LOCK,
		2'h0};
	localparam logic [7:0] ACTION_RESET = 8'h00;

	// measurement window is 2^(14 + range) reference cycles
	localparam int WIN_BASE_EXP = 14;
	localparam int WIN_W        = 18;
	localparam int COUNT_W      = 23;

	// measurement timing guard
	localparam int CLK_MHZ       = 125;
	localparam int MEAS_TYP_MS   = 80;
	localparam int MEAS_GUARD_X  = 2;
	localparam int MEAS_LIMIT_CYC = MEAS_GUARD_X * MEAS_TYP_MS * 1000 *
		CLK_MHZ;
	localparam int GUARD_W       = 25;

	typedef enum logic [1:0] {
		MEAS_IDLE,
		MEAS_ARM,
		MEAS_RUN,
		MEAS_DONE
	} meas_state_type;

endpackage

// >>> host_model.sv
/*
 * Host model: drives the register port of the rate meter in place of the
 * serial bus front end.
 * Assumes the design samples the port on the rising edge of clk.
 */
`timescale 1ns/1ps
module host_model (
	input  wire logic       clk,       // system clock
	output logic      [2:0] regAddr,   // subaddress
	output logic            regWrEn,   // write strobe
	output logic      [7:0] regWrData, // write data
	output logic            regRdEn,   // read strobe
	input  wire logic [7:0] regRdData  // read data
);
	initial begin
		regAddr = 3'h7;
		regWrEn = 1'b0;
		regWrData = 8'h00;
		regRdEn = 1'b0;
	end

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(posedge clk);
		#1;
		regWrEn = 1'b0;
		regWrData = ~d;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		regAddr = a;
		regRdEn = 1'b1;
		@(posedge clk);
		#1;
		regRdEn = 1'b0;
		@(posedge clk);
		#1;
		d = regRdData;
	endtask
endmodule

// >>> reference_clock_in_lock_and_rate_meter_test.sv
/*
 * Self-checking bench for the reference clock lock and rate meter.
 * Assumes host_model and the package are compiled first.
 */
`timescale 1ns/1ps
module reference_clock_in_lock_and_rate_meter_test;
	import reference_clock_in_rate_pkg::*;
	logic        clk = 0, rstn = 0, reference_clock_in = 0, dataTick = 0;
	logic        lockLostFlag = 0, tickOn = 0, rdSeen = 0;
	logic [2:0]  regAddr;
	logic        regWrEn, regRdEn, refLockMode, refDivTick, relockReq;
	logic        refInUse;
	logic [7:0]  regWrData, regRdData, d, v;
	logic [3:0]  lockRatio;
	logic [15:0] expQ[$];
	logic [15:0] e;
	logic [31:0] tickCnt = 0, r;
	int          num_errors = 0, num_checks = 0, n, i, k;

	always #4 clk = ~clk;
	initial begin
		#3.3;
		forever #32 reference_clock_in = ~reference_clock_in;
	end

	reference_clock_in_lock_and_rate_meter #(.MEAS_LIMIT(20000)) dut (.clk(clk),
		.rstn(rstn), .referenceClockIn(reference_clock_in), .regAddr(regAddr),
		.regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
		.regRdData(regRdData), .dataTick(dataTick),
		.lockLostFlag(lockLostFlag), .refLockMode(refLockMode),
		.lockRatio(lockRatio), .refDivTick(refDivTick),
		.relockReq(relockReq), .refInUse(refInUse));
	host_model host (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn),
		.regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));

	// one data tick every fourth clock while enabled
	always @(posedge clk) begin
		#1;
		tickCnt = tickCnt + 1;
		dataTick = tickOn && tickCnt[1:0] == 2'h0;
	end

	task automatic check(input bit ok, input string msg);
		num_checks++;
		if (!ok) begin
			num_errors++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask

	// entry is {mask, expected}
	always @(posedge clk) begin
		if (rdSeen && expQ.size() > 0) begin
			e = expQ.pop_front();
			check(((regRdData ^ e[7:0]) & e[15:8]) === 8'h00, "read data");
		end
		rdSeen <= regRdEn;
	end

	task automatic expect_rd(input logic [2:0] a, input logic [7:0] x,
		input logic [7:0] m);
		logic [7:0] t;
		expQ.push_back({m, x});
		host.rd(a, t);
	endtask

	task automatic count_div(input int c, output int cnt);
		cnt = 0;
		repeat (c) begin
			@(posedge clk);
			#1;
			if (refDivTick === 1'b1) cnt++;
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		#720000;
		check(1'b0, "run timeout");
		tally_and_finish();
	end

	initial begin
		r = $urandom(32'hd1d9);
		repeat (40) @(posedge clk);
		check(refInUse === 1'b0 && relockReq === 1'b0 &&
			regRdData === 8'h00, "reset outputs");
		#1;
		rstn = 1'b1;
		expect_rd(ADDR_RATE_CTRL, RATE_CTRL_RESET, 8'hff);
		host.wr(3'h6, 8'($urandom()));
		expect_rd(3'h6, 8'h00, 8'hff);
		v = $urandom() & 8'hf7;
		host.wr(ADDR_ACTION, v);
		expect_rd(ADDR_ACTION, v, 8'hff);
		host.wr(ADDR_ACTION, 8'h00);
		host.wr(ADDR_RATE_CTRL, 8'h15);
		check(relockReq === 1'b1 && refInUse === 1'b0, "lock cmd");
		@(posedge clk);
		#1;
		check(relockReq === 1'b0 && refLockMode === 1'b1 &&
			refInUse === 1'b1 && lockRatio === RATIO_LOCK,
			"lock mode");
		r = $urandom_range(3);
		host.wr(ADDR_RATE_CTRL, {r[1:0], RATIO_LOCK, 2'b01});
		repeat (8) @(posedge clk);
		count_div(1600, n);
		check(n >= (200 >> r) - 2 && n <= (200 >> r) + 1, "ref div");
		lockLostFlag = 1'b1;
		n = 0;
		repeat (4) begin
			@(posedge clk);
			#1;
			if (relockReq === 1'b1) n++;
		end
		check(n == 1, "relock on loss");
		expect_rd(ADDR_STATUS, 8'h01, 8'h01);
		lockLostFlag = 1'b0;
		host.wr(ADDR_RATE_CTRL, 8'h14);
		repeat (8) @(posedge clk);
		count_div(100, n);
		check(n == 0 && refInUse === 1'b0, "no reference");
		host.wr(ADDR_RATE_CTRL, 8'h17);
		repeat (3) @(posedge clk);
		#1;
		check(refInUse === 1'b0 && refLockMode === 1'b0, "both set");
		host.wr(ADDR_RATE_CTRL, 8'h16);
		tickOn = 1'b1;
		for (k = 0; k < 2; k++) begin
			host.wr(ADDR_ACTION, 8'h08);
			host.wr(ADDR_ACTION, 8'h00);
			expect_rd(ADDR_STATUS, 8'h00, 8'h04);
			d = 8'h00;
			i = 0;
			while (d[STAT_DONE_BIT] !== 1'b1 && i < 40) begin
				repeat (1000) @(posedge clk);
				expQ.push_back(16'h0000);
				host.rd(ADDR_STATUS, d);
				i++;
			end
			if (d[STAT_DONE_BIT] !== 1'b1) begin
				check(1'b0, "done wait");
				tally_and_finish();
			end
			check(i >= 19, "done too early");
			expect_rd(ADDR_CNT_HIGH, 8'h00, 8'hff);
			expect_rd(ADDR_CNT_MID, 8'h13, 8'hff);
		end
		tally_and_finish();
	end
endmodule
